// ### rtl/cbc_cmd_regs.sv
// Bus slave and command registers of the smart charger
`timescale 1ns/1ps
module cbc_cmd_regs (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        scl,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        pack_inserted_flag,
	input  wire logic        power_fail,
	input  wire logic        pack_overtemp_flag,
	input  wire logic        sensor_underrange_flag,
	input  wire logic        overvolt_compare_out,
	input  wire logic        volt_clamp_active,
	input  wire logic [1:0]  range_sel,
	output logic             charge_en,
	output logic             trickle_source,
	output logic [4:0]       switcher_amp_code,
	output logic [10:0]      volt_dac_code,
	output logic             irq,
	output logic [15:0]      status_word
);

	// ------------------------------------------------------------
	// Bus wire sensing
	// ------------------------------------------------------------
	logic scl_rise, scl_fall, bus_start, bus_stop, sda_bit;

	cbc_bus_sense u_sense (
		.clk       (clk),
		.arst_n    (arst_n),
		.scl       (scl),
		.sda_in    (sda_in),
		.scl_rise  (scl_rise),
		.scl_fall  (scl_fall),
		.bus_start (bus_start),
		.bus_stop  (bus_stop),
		.sda_bit   (sda_bit)
	);

	// ------------------------------------------------------------
	// Slave byte engine
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		CBC_IDLE, CBC_ADDR, CBC_CMD, CBC_DLO, CBC_DHI,
		CBC_ACK, CBC_TXLO, CBC_TXHI, CBC_MACK
	} cbc_state_t;

	cbc_state_t  st_q, st_d, after_q, after_d;
	logic [3:0]  cnt_q, cnt_d;
	logic [7:0]  sh_q, sh_d;
	logic [7:0]  cmd_q, cmd_d;
	logic [7:0]  lo_q, lo_d;
	logic [15:0] tx_q, tx_d;
	logic        oe_q, oe_d;
	logic        mack_q, mack_d;
	logic        hi_tx_q, hi_tx_d;
	logic        wr_stb_q, wr_stb_d;
	logic [15:0] wr_data_q, wr_data_d;
	logic        rd_done_q, rd_done_d;
	logic        cmd_ok;

	// Read word only makes sense after the status command
	always_comb begin
		cmd_ok = (sh_q == cbc_pkg::CMD_MODE) || (sh_q == cbc_pkg::CMD_STATUS) ||
			(sh_q == cbc_pkg::CMD_AMP) || (sh_q == cbc_pkg::CMD_VOLT) ||
			(sh_q == cbc_pkg::CMD_ALARM);
	end

	always_comb begin
		st_d      = st_q;
		after_d   = after_q;
		cnt_d     = cnt_q;
		sh_d      = sh_q;
		cmd_d     = cmd_q;
		lo_d      = lo_q;
		tx_d      = tx_q;
		oe_d      = oe_q;
		mack_d    = mack_q;
		hi_tx_d   = hi_tx_q;
		wr_stb_d  = 1'b0;
		wr_data_d = wr_data_q;
		rd_done_d = 1'b0;
		if (bus_stop) begin
			st_d = CBC_IDLE;
			oe_d = 1'b0;
		end else if (bus_start) begin
			// Repeated start is allowed; the command byte is kept
			st_d  = CBC_ADDR;
			cnt_d = 4'h0;
			oe_d  = 1'b0;
		end else begin
			unique case (st_q)
				CBC_IDLE: begin
				end
				CBC_ADDR, CBC_CMD, CBC_DLO, CBC_DHI: begin
					if (scl_rise && cnt_q < 4'h8) begin
						sh_d  = {sh_q[6:0], sda_bit};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						cnt_d = 4'h0;
						oe_d  = 1'b1;
						st_d  = CBC_ACK;
						if (st_q == CBC_ADDR) begin
							if (sh_q == {cbc_pkg::DEV_ADDR, 1'b0}) begin
								after_d = CBC_CMD;
							end else if (sh_q == {cbc_pkg::DEV_ADDR, 1'b1} &&
								cmd_q == cbc_pkg::CMD_STATUS) begin
								after_d = CBC_TXLO;
								tx_d    = status_word;
							end else begin
								oe_d = 1'b0;
								st_d = CBC_IDLE;
							end
						end else if (st_q == CBC_CMD) begin
							cmd_d   = sh_q;
							after_d = CBC_DLO;
							if (!cmd_ok) begin
								oe_d = 1'b0;
								st_d = CBC_IDLE;
							end
						end else if (st_q == CBC_DLO) begin
							lo_d    = sh_q;
							after_d = CBC_DHI;
						end else begin
							// Word complete once its high byte is shifted in, as its acknowledge starts
							wr_stb_d  = (cmd_q != cbc_pkg::CMD_STATUS);
							wr_data_d = {sh_q, lo_q};
							after_d   = CBC_IDLE;
						end
					end
				end
				CBC_ACK: begin
					if (scl_fall) begin
						st_d    = after_q;
						cnt_d   = 4'h0;
						hi_tx_d = 1'b0;
						oe_d    = 1'b0;
						if (after_q == CBC_TXLO) begin
							oe_d = ~tx_q[7];
						end
					end
				end
				CBC_TXLO, CBC_TXHI: begin
					if (scl_rise && cnt_q < 4'h8) begin
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						oe_d = 1'b0;
						st_d = CBC_MACK;
						hi_tx_d = (st_q == CBC_TXHI);
					end else if (scl_fall) begin
						if (st_q == CBC_TXLO) begin
							oe_d = ~tx_q[7 - 3'(cnt_q)];
						end else begin
							oe_d = ~tx_q[15 - 4'(cnt_q)];
						end
					end
				end
				CBC_MACK: begin
					if (scl_rise) begin
						mack_d = ~sda_bit;
					end else if (scl_fall) begin
						cnt_d = 4'h0;
						if (!hi_tx_q && mack_q) begin
							st_d = CBC_TXHI;
							oe_d = ~tx_q[15];
						end else begin
							st_d      = CBC_IDLE;
							rd_done_d = hi_tx_q;
						end
					end
				end
			endcase
		end
	end

	// The slave only ever pulls low on acknowledge or data
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q      <= CBC_IDLE;
			after_q   <= CBC_IDLE;
			cnt_q     <= 4'h0;
			sh_q      <= 8'h00;
			cmd_q     <= 8'h00;
			lo_q      <= 8'h00;
			tx_q      <= 16'h0000;
			oe_q      <= 1'b0;
			mack_q    <= 1'b0;
			hi_tx_q   <= 1'b0;
			wr_stb_q  <= 1'b0;
			wr_data_q <= 16'h0000;
			rd_done_q <= 1'b0;
		end else begin
			st_q      <= st_d;
			after_q   <= after_d;
			cnt_q     <= cnt_d;
			sh_q      <= sh_d;
			cmd_q     <= cmd_d;
			lo_q      <= lo_d;
			tx_q      <= tx_d;
			oe_q      <= oe_d;
			mack_q    <= mack_d;
			hi_tx_q   <= hi_tx_d;
			wr_stb_q  <= wr_stb_d;
			wr_data_q <= wr_data_d;
			rd_done_q <= rd_done_d;
		end
	end

	// ------------------------------------------------------------
	// Command registers and flags
	// ------------------------------------------------------------
	logic [15:0] mode_q, mode_d;
	logic [15:0] volt_q, volt_d;
	logic [15:0] amp_q, amp_d;
	logic        alarm_q, alarm_d;
	logic        hot_q, hot_d;
	logic        pack_q, pf_q;
	logic        irq_q, irq_d;
	logic        por_wr, wr_mode, wr_volt, wr_amp, wr_alarm;

	always_comb begin
		wr_mode  = wr_stb_q && cmd_q == cbc_pkg::CMD_MODE;
		wr_volt  = wr_stb_q && cmd_q == cbc_pkg::CMD_VOLT;
		wr_amp   = wr_stb_q && cmd_q == cbc_pkg::CMD_AMP;
		wr_alarm = wr_stb_q && cmd_q == cbc_pkg::CMD_ALARM;
		por_wr   = wr_mode && wr_data_q[cbc_pkg::MODE_POR];
		mode_d   = mode_q;
		volt_d   = volt_q;
		amp_d    = amp_q;
		if (wr_mode) begin
			mode_d = wr_data_q;
		end
		if (wr_volt) begin
			volt_d = wr_data_q & cbc_pkg::VOLT_LSB_MASK;
		end
		if (wr_amp) begin
			amp_d = wr_data_q;
		end
		if (por_wr) begin
			volt_d = cbc_pkg::VOLT_POR_CMD;
			amp_d  = cbc_pkg::AMP_RESET;
		end
		if (!pack_inserted_flag) begin
			mode_d[cbc_pkg::MODE_OVERTEMP_HALT_BIT] = 1'b1;
			volt_d = cbc_pkg::VOLT_RESET;
			amp_d  = cbc_pkg::AMP_RESET;
		end
		// Alarm set wins over any simultaneous clear
		alarm_d = wr_alarm ? 1'b1 :
			(por_wr || wr_volt || wr_amp || !pack_inserted_flag) ? 1'b0 : alarm_q;
		// Hot condition latches; reset command clears unless still hot
		hot_d = pack_overtemp_flag ? 1'b1 : por_wr ? 1'b0 : hot_q;
		// Edge of an unmasked pack or power fail status raises the line; status read clears
		irq_d = irq_q;
		if (rd_done_q) begin
			irq_d = 1'b0;
		end
		if ((pack_q != pack_inserted_flag && !mode_q[cbc_pkg::MODE_PACK_MSK]) ||
			(pf_q != power_fail && !mode_q[cbc_pkg::MODE_PF_MSK])) begin
			irq_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q  <= cbc_pkg::MODE_RESET;
			volt_q  <= cbc_pkg::VOLT_RESET;
			amp_q   <= cbc_pkg::AMP_RESET;
			alarm_q <= 1'b0;
			hot_q   <= 1'b0;
			pack_q  <= 1'b0;
			pf_q    <= 1'b0;
			irq_q   <= 1'b0;
		end else begin
			mode_q  <= mode_d;
			volt_q  <= volt_d;
			amp_q   <= amp_d;
			alarm_q <= alarm_d;
			hot_q   <= hot_d;
			pack_q  <= pack_inserted_flag;
			pf_q    <= power_fail;
			irq_q   <= irq_d;
		end
	end

	// ------------------------------------------------------------
	// Regulator controls and status
	// ------------------------------------------------------------
	logic [15:0] fs_ma;
	logic [4:0]  code_n;
	logic [10:0] vcode_n;
	logic        amp_or, volt_or, chg_n, trk_n;
	logic [15:0] stat_n;

	always_comb begin
		// Open strap pins read as the middle level; unknown code treated low
		unique case (range_sel)
			cbc_pkg::SEL_OPEN: fs_ma = cbc_pkg::AMP_FS_OPEN;
			cbc_pkg::SEL_HIGH: fs_ma = cbc_pkg::AMP_FS_HIGH;
			default:           fs_ma = cbc_pkg::AMP_FS_LOW;
		endcase
		amp_or  = amp_q > fs_ma;
		// Step stays 128 mA; only the clamp point moves
		code_n  = amp_or ? fs_ma[cbc_pkg::AMP_CODE_LSB +: 5]
			: amp_q[cbc_pkg::AMP_CODE_LSB +: 5];
		volt_or = volt_q > cbc_pkg::VOLT_MAX;
		vcode_n = volt_or ? cbc_pkg::VOLT_MAX[14:4] : volt_q[14:4];
		chg_n   = !mode_q[cbc_pkg::MODE_INHIBIT] && pack_inserted_flag &&
			!(mode_q[cbc_pkg::MODE_OVERTEMP_HALT_BIT] && pack_overtemp_flag);
		// Trickle only with zero switcher code and no overvoltage
		trk_n   = chg_n && code_n == 5'h00 && amp_q != 16'h0000 &&
			!overvolt_compare_out;
		stat_n  = 16'h0000;
		stat_n[cbc_pkg::ST_CHG_OFF]   = mode_q[cbc_pkg::MODE_INHIBIT];
		stat_n[cbc_pkg::ST_OVERTEMP_HALT_BIT]  = mode_q[cbc_pkg::MODE_OVERTEMP_HALT_BIT];
		stat_n[cbc_pkg::ST_VOLT_NREG] = volt_clamp_active;
		stat_n[cbc_pkg::ST_AMP_OR]    = amp_or;
		stat_n[cbc_pkg::ST_VOLT_OR]   = volt_or;
		stat_n[cbc_pkg::ST_HOT]       = hot_q;
		stat_n[cbc_pkg::ST_UR]        = sensor_underrange_flag;
		stat_n[cbc_pkg::ST_ALARM]     = alarm_q;
		stat_n[cbc_pkg::ST_PWR_FAIL]  = power_fail;
		stat_n[cbc_pkg::ST_PACK]      = pack_inserted_flag;
		stat_n[cbc_pkg::ST_IRQ]       = irq_q;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			charge_en         <= 1'b0;
			trickle_source    <= 1'b0;
			switcher_amp_code <= 5'h00;
			volt_dac_code     <= 11'h000;
			status_word       <= 16'h0000;
		end else begin
			charge_en         <= chg_n;
			trickle_source    <= trk_n;
			switcher_amp_code <= chg_n ? code_n : 5'h00;
			volt_dac_code     <= vcode_n;
			status_word       <= stat_n;
		end
	end

	// Open drain: the level driven is always low
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sda_out <= 1'b0;
			sda_oe  <= 1'b0;
			irq     <= 1'b0;
		end else begin
			sda_out <= 1'b0;
			sda_oe  <= oe_q;
			irq     <= irq_q;
		end
	end

endmodule

// ### rtl/cbc_pkg.sv
// Shared constants for the charger bus command block
package cbc_pkg;

	// ------------------------------------------------------------
	// Bus address and command codes
	// ------------------------------------------------------------
	localparam logic [6:0]  DEV_ADDR      = 7'h09;
	localparam logic [7:0]  CMD_MODE      = 8'h12;
	localparam logic [7:0]  CMD_STATUS    = 8'h13;
	localparam logic [7:0]  CMD_AMP       = 8'h14;
	localparam logic [7:0]  CMD_VOLT      = 8'h15;
	localparam logic [7:0]  CMD_ALARM     = 8'h16;

	// ------------------------------------------------------------
	// Mode word fields and reset values
	// ------------------------------------------------------------
	localparam int          MODE_INHIBIT  = 0;
	localparam int          MODE_POR      = 2;
	localparam int          MODE_PACK_MSK = 5;
	localparam int          MODE_PF_MSK   = 6;
	localparam int          MODE_OVERTEMP_HALT_BIT = 10;
	localparam logic [15:0] MODE_RESET    = 16'hffd0;

	// ------------------------------------------------------------
	// Set points
	// ------------------------------------------------------------
	localparam logic [15:0] VOLT_MAX      = 16'h47f0;
	localparam logic [15:0] VOLT_RESET    = 16'h47f0;
	localparam logic [15:0] VOLT_POR_CMD  = 16'hffff;
	localparam logic [15:0] VOLT_LSB_MASK = 16'hfff0;
	localparam logic [15:0] AMP_RESET     = 16'h0007;
	localparam logic [15:0] AMP_FS_LOW    = 16'd896;
	localparam logic [15:0] AMP_FS_OPEN   = 16'd2944;
	localparam logic [15:0] AMP_FS_HIGH   = 16'd3968;
	localparam int          AMP_CODE_LSB  = 7;
	localparam logic [1:0]  SEL_LOW       = 2'h0;
	localparam logic [1:0]  SEL_OPEN      = 2'h1;
	localparam logic [1:0]  SEL_HIGH      = 2'h2;

	// ------------------------------------------------------------
	// Status word bit positions
	// ------------------------------------------------------------
	localparam int          ST_CHG_OFF    = 0;
	localparam int          ST_OVERTEMP_HALT_BIT   = 1;
	localparam int          ST_VOLT_NREG  = 2;
	localparam int          ST_AMP_OR     = 4;
	localparam int          ST_VOLT_OR    = 5;
	localparam int          ST_HOT        = 6;
	localparam int          ST_UR         = 7;
	localparam int          ST_ALARM      = 8;
	localparam int          ST_PWR_FAIL   = 13;
	localparam int          ST_PACK       = 14;
	localparam int          ST_IRQ        = 15;

endpackage

// ### rtl/cbc_bus_sense.sv
// Edge and start/stop detector for the two bus wires
`timescale 1ns/1ps
module cbc_bus_sense (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic scl,
	input  wire logic sda_in,
	output logic      scl_rise,
	output logic      scl_fall,
	output logic      bus_start,
	output logic      bus_stop,
	output logic      sda_bit
);

	// ------------------------------------------------------------
	// Sampling
	// ------------------------------------------------------------
	logic scl_q, scl_d, sda_q, sda_d;
	logic rise_d, fall_d, start_d, stop_d;

	always_comb begin
		scl_d   = scl;
		sda_d   = sda_in;
		rise_d  = scl & ~scl_q;
		fall_d  = ~scl & scl_q;
		// Data edge while clock stays high marks frame boundaries
		start_d = scl & scl_q & sda_q & ~sda_in;
		stop_d  = scl & scl_q & ~sda_q & sda_in;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_q     <= 1'b1;
			sda_q     <= 1'b1;
			scl_rise  <= 1'b0;
			scl_fall  <= 1'b0;
			bus_start <= 1'b0;
			bus_stop  <= 1'b0;
			sda_bit   <= 1'b1;
		end else begin
			scl_q     <= scl_d;
			sda_q     <= sda_d;
			scl_rise  <= rise_d;
			scl_fall  <= fall_d;
			bus_start <= start_d;
			bus_stop  <= stop_d;
			sda_bit   <= sda_d;
		end
	end

endmodule

// ### tb/cbc_host_model.sv
// Bus master model issuing word writes and word reads
`timescale 1ns/1ps
module cbc_host_model (
	input  wire logic clk,
	input  wire logic sda_wire,
	output logic      scl,
	output logic      sda_drv
);
	// ------------------------------------------------------------
	// Wire primitives
	// ------------------------------------------------------------
	// Bus idles high through the pull-up
	initial begin
		scl = 1'b1;
		sda_drv = 1'b0;
	end

	task automatic hw(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Data moves only while the clock is low; phases at least 4 clk
	task automatic bit_x(input logic b, output logic r);
		sda_drv <= ~b;
		hw(8);
		scl <= 1'b1;
		hw(8);
		r = sda_wire;
		scl <= 1'b0;
		hw(4);
	endtask

	task automatic xbyte(input logic [7:0] d, input logic ak, output logic [7:0] q,
		output logic a);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
			q = {q[6:0], r};
		end
		bit_x(ak, a);
	endtask

	// Release first so a repeated start never races the clock rising
	task automatic start();
		hw(1);
		sda_drv <= 1'b0;
		hw(4);
		scl <= 1'b1;
		hw(8);
		sda_drv <= 1'b1;
		hw(8);
		scl <= 1'b0;
		hw(4);
	endtask

	task automatic stop();
		sda_drv <= 1'b1;
		hw(4);
		scl <= 1'b1;
		hw(8);
		sda_drv <= 1'b0;
		hw(8);
	endtask

	// ------------------------------------------------------------
	// Word transfers, low byte then high byte
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] ad, input logic [7:0] c, input logic [15:0] d,
		output logic ok);
		logic [7:0] q;
		logic [3:0] a;
		start();
		xbyte(ad, 1'b1, q, a[0]);
		xbyte(c, 1'b1, q, a[1]);
		xbyte(d[7:0], 1'b1, q, a[2]);
		xbyte(d[15:8], 1'b1, q, a[3]);
		stop();
		ok = (a == 4'h0);
	endtask

	task automatic rd(output logic [15:0] d, output logic ok);
		logic [7:0] q;
		logic [2:0] a;
		logic       x;
		start();
		xbyte({cbc_pkg::DEV_ADDR, 1'b0}, 1'b1, q, a[0]);
		xbyte(cbc_pkg::CMD_STATUS, 1'b1, q, a[1]);
		start();
		xbyte({cbc_pkg::DEV_ADDR, 1'b1}, 1'b1, q, a[2]);
		xbyte(8'hff, 1'b0, d[7:0], x);
		xbyte(8'hff, 1'b1, d[15:8], x);
		stop();
		ok = (a == 3'h0);
	endtask
endmodule

// ### tb/cbc_cmd_regs_sva.sv
// Port-level checks of the charger command block
`timescale 1ns/1ps
module cbc_cmd_regs_sva (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        scl,
	input wire logic        sda_in,
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic        pack_inserted_flag,
	input wire logic        power_fail,
	input wire logic        pack_overtemp_flag,
	input wire logic        sensor_underrange_flag,
	input wire logic        overvolt_compare_out,
	input wire logic        volt_clamp_active,
	input wire logic [1:0]  range_sel,
	input wire logic        charge_en,
	input wire logic        trickle_source,
	input wire logic [4:0]  switcher_amp_code,
	input wire logic [10:0] volt_dac_code,
	input wire logic        irq,
	input wire logic [15:0] status_word
);
	// Outputs lag reset release; the no-pack checks hold off until they settle
	logic [2:0] up_q;
	logic [2:0] up_d;
	always_comb begin
		up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			up_q <= 3'h0;
		end else begin
			up_q <= up_d;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_no_pack;
		(!pack_inserted_flag)[*4] ##0 (up_q == 3'h7);
	endsequence
	sequence s_low_strap;
		(range_sel != cbc_pkg::SEL_OPEN && range_sel != cbc_pkg::SEL_HIGH)[*4];
	endsequence

	a_no_pack_halt: assert property (s_no_pack |-> status_word[cbc_pkg::ST_OVERTEMP_HALT_BIT]
		&& !charge_en) else $error("halt bit or charge wrong without pack");
	a_no_pack_volt: assert property (s_no_pack |-> volt_dac_code == 11'h47f)
		else $error("voltage not at reset value without pack");
	a_no_pack_amp: assert property (s_no_pack |-> switcher_amp_code == 5'h00
		&& !status_word[cbc_pkg::ST_ALARM]) else $error("current or alarm kept without pack");
	a_volt_ceiling: assert property (volt_dac_code <= 11'h47f)
		else $error("voltage code above ceiling");
	a_trickle_code: assert property ((switcher_amp_code != 5'h00)[*2] |-> !trickle_source)
		else $error("trickle on with switcher code");
	a_ov_trickle: assert property (overvolt_compare_out[*4] |-> !trickle_source)
		else $error("trickle on with comparator high");
	a_clamp_flag: assert property (volt_clamp_active[*4] |-> status_word[cbc_pkg::ST_VOLT_NREG])
		else $error("unregulated flag missing");
	a_inhibit_off: assert property (status_word[cbc_pkg::ST_CHG_OFF][*3] |-> !charge_en)
		else $error("charging while inhibited");
	a_low_scale: assert property (s_low_strap |-> switcher_amp_code <= 5'h07)
		else $error("code above low full scale");
	a_slave_drive: assert property ($changed(sda_oe) |-> !scl && !sda_out)
		else $error("data line moved while clock high");
	a_drive_low: assert property (sda_oe |-> !sda_out)
		else $error("data line driven high");
endmodule

bind cbc_cmd_regs cbc_cmd_regs_sva chk_u (.clk(clk), .arst_n(arst_n), .scl(scl),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.pack_inserted_flag(pack_inserted_flag), .power_fail(power_fail),
	.pack_overtemp_flag(pack_overtemp_flag), .sensor_underrange_flag(sensor_underrange_flag),
	.overvolt_compare_out(overvolt_compare_out), .volt_clamp_active(volt_clamp_active),
	.range_sel(range_sel), .charge_en(charge_en), .trickle_source(trickle_source),
	.switcher_amp_code(switcher_amp_code), .volt_dac_code(volt_dac_code), .irq(irq),
	.status_word(status_word));

// ### tb/cbc_cmd_regs_tb_top.sv
// Self-checking bench for the charger command block
`timescale 1ns/1ps
module cbc_cmd_regs_tb_top;
	localparam logic [7:0] WA = {cbc_pkg::DEV_ADDR, 1'b0};
	localparam logic [4:0] CODE_T [4] = '{5'h07, 5'h17, 5'h17, 5'h07};
	localparam logic [3:0] OR_T = 4'b1011;
	logic        clk, arst_n, scl, host_pull, sda_wire, sda_out, sda_oe, ok;
	logic        pack, pf, hot, ur, ov, clamp, charge_en, trickle, irq;
	logic [1:0]  sel;
	logic [4:0]  code;
	logic [10:0] vdac;
	logic [15:0] st, rdat;
	int          n_errors, compares;

	initial clk = 1'b0;
	always #12.5 clk = ~clk;
	// Open-drain wire with pull-up
	assign sda_wire = (sda_oe ? sda_out : 1'b1) & ~host_pull;

	cbc_host_model host_u (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(host_pull));
	cbc_cmd_regs dut_u (.clk(clk), .arst_n(arst_n), .scl(scl), .sda_in(sda_wire),
		.sda_out(sda_out), .sda_oe(sda_oe), .pack_inserted_flag(pack), .power_fail(pf),
		.pack_overtemp_flag(hot), .sensor_underrange_flag(ur), .overvolt_compare_out(ov),
		.volt_clamp_active(clamp), .range_sel(sel), .charge_en(charge_en),
		.trickle_source(trickle), .switcher_amp_code(code), .volt_dac_code(vdac),
		.irq(irq), .status_word(st));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic finish_test();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Samples at the falling edge, clear of the launching edge
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic look(input string nm, input logic [15:0] s, input logic c, input logic t,
		input logic [4:0] k, input logic [10:0] v = 11'h47f);
		chk({nm, " status"}, st, s);
		chk({nm, " irq"}, 16'(irq), 16'(s[15]));
		chk({nm, " charge"}, 16'(charge_en), 16'(c));
		chk({nm, " trickle"}, 16'(trickle), 16'(t));
		chk({nm, " code"}, 16'(code), 16'(k));
		chk({nm, " volt"}, 16'(vdac), 16'(v));
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] c, input logic [15:0] d,
		input logic e);
		logic r;
		host_u.wr(a, c, d, r);
		chk("ack", 16'(r), 16'(e));
		wt(6);
	endtask

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		finish_test();
	end

	initial begin
		arst_n = 1'b0;
		{pack, pf, hot, ur, ov, clamp} = 6'h00;
		sel = 2'h0;
		n_errors = 0;
		compares = 0;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		wt(8);
		look("por", 16'h0002, 1'b0, 1'b0, 5'h00);
		@(posedge clk) pack <= 1'b1;
		wt(4);
		look("insert", 16'hc002, 1'b1, 1'b1, 5'h00);
		host_u.rd(rdat, ok);
		chk("read ack", 16'(ok), 16'h0001);
		chk("read data", rdat, 16'hc002);
		wt(4);
		look("read", 16'h4002, 1'b1, 1'b1, 5'h00);
		wr(8'h14, cbc_pkg::CMD_MODE, 16'hffd1, 1'b0);
		wr(WA, 8'h17, 16'hffd1, 1'b0);
		look("refused", 16'h4002, 1'b1, 1'b1, 5'h00);
		wr(WA, cbc_pkg::CMD_AMP, 16'h0200, 1'b1);
		look("amp", 16'h4002, 1'b1, 1'b0, 5'h04);
		wr(WA, cbc_pkg::CMD_AMP, 16'h0bb8, 1'b1);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) sel <= 2'(i);
			wt(4);
			look("strap", 16'h4002 | 16'(OR_T[i]) << 4, 1'b1, 1'b0, CODE_T[i]);
		end
		@(posedge clk) sel <= cbc_pkg::SEL_HIGH;
		wr(WA, cbc_pkg::CMD_VOLT, 16'h5000, 1'b1);
		look("v over", 16'h4022, 1'b1, 1'b0, 5'h17);
		wr(WA, cbc_pkg::CMD_VOLT, 16'h123f, 1'b1);
		look("v set", 16'h4002, 1'b1, 1'b0, 5'h17, 11'h123);
		wr(WA, cbc_pkg::CMD_ALARM, 16'h0000, 1'b1);
		look("alarm", 16'h4102, 1'b1, 1'b0, 5'h17, 11'h123);
		wr(WA, cbc_pkg::CMD_VOLT, 16'h123f, 1'b1);
		look("alarm off", 16'h4002, 1'b1, 1'b0, 5'h17, 11'h123);
		wr(WA, cbc_pkg::CMD_MODE, 16'hffd1, 1'b1);
		look("inhibit", 16'h4003, 1'b0, 1'b0, 5'h00, 11'h123);
		wr(WA, cbc_pkg::CMD_MODE, 16'hffd0, 1'b1);
		look("allow", 16'h4002, 1'b1, 1'b0, 5'h17, 11'h123);
		@(posedge clk) hot <= 1'b1;
		wt(4);
		look("hot", 16'h4042, 1'b0, 1'b0, 5'h00, 11'h123);
		wr(WA, cbc_pkg::CMD_MODE, 16'hfbd0, 1'b1);
		look("hot run", 16'h4040, 1'b1, 1'b0, 5'h17, 11'h123);
		@(posedge clk) hot <= 1'b0;
		wr(WA, cbc_pkg::CMD_ALARM, 16'h0000, 1'b1);
		wr(WA, cbc_pkg::CMD_MODE, 16'hfbd4, 1'b1);
		look("defaults", 16'h4020, 1'b1, 1'b1, 5'h00);
		@(posedge clk) ov <= 1'b1;
		wt(4);
		look("ov", 16'h4020, 1'b1, 1'b0, 5'h00);
		@(posedge clk) {ov, clamp, ur} <= 3'b011;
		wt(4);
		look("clamp", 16'h40a4, 1'b1, 1'b1, 5'h00);
		@(posedge clk) {pf, clamp, ur} <= 3'b100;
		wt(4);
		look("pf masked", 16'h6020, 1'b1, 1'b1, 5'h00);
		wr(WA, cbc_pkg::CMD_MODE, 16'hfbb0, 1'b1);
		@(posedge clk) pf <= 1'b0;
		wt(4);
		look("pf edge", 16'hc020, 1'b1, 1'b1, 5'h00);
		wr(WA, cbc_pkg::CMD_VOLT, 16'h1230, 1'b1);
		@(posedge clk) pack <= 1'b0;
		wt(4);
		look("removed", 16'h8002, 1'b0, 1'b0, 5'h00);
		finish_test();
	end
endmodule
